// ==== core/trim_regs_pkg.sv ====
// Constants, field positions and carrier types for the regulator trim bank.
// Assumes a 32-bit byte-addressed register port and a single system clock.
package trim_regs_pkg;

    // Byte addresses of the four trim words and of the unlock key.
    localparam logic [31:0] ADDR_WORD0 = 32'h50018000;
    localparam logic [31:0] ADDR_WORD1 = 32'h50018004;
    localparam logic [31:0] ADDR_WORD2 = 32'h50018008;
    localparam logic [31:0] ADDR_WORD3 = 32'h5001800C;
    localparam logic [31:0] ADDR_UNLOCK = 32'h50018020;

    // Value that opens the trim words to software.
    localparam logic [31:0] UNLOCK_VALUE = 32'h1D155AFE;
    // Number of trim words held.
    localparam int NUM_WORDS = 4;

    // Reset values of the trim words.
    localparam logic [31:0] WORD0_RESET = 32'h8200000A;
    localparam logic [31:0] WORD1_RESET = 32'h40000080;
    localparam logic [31:0] WORD2_RESET = 32'h00000808;
    localparam logic [31:0] WORD3_RESET = 32'h000A0000;

    // Field positions in word 0.
    localparam int HOLD_FIXED_BIT = 31;
    localparam int FIXED_MASK_BIT = 30;
    localparam int FIXED_INJECT_BIT = 29;
    localparam int SKIP_MASK_BIT = 28;
    localparam int SKIP_INJECT_BIT = 27;
    localparam int FAST_GATE_BIT = 26;
    localparam int IGNORE_BYPASS_BIT = 25;
    localparam int CLOCK_DRIVES_BIT = 24;
    localparam int TIMEOUT_IGN_HI = 23;
    localparam int TIMEOUT_IGN_LO = 16;
    localparam int FORCE_MAG_BIT = 15;
    localparam int FORCE_DEMAG_BIT = 14;
    localparam int PAUSE_HI = 13;
    localparam int PAUSE_LO = 10;
    localparam int LOW_OFF_BIT = 9;
    localparam int SEQ_MAG_MASK_BIT = 8;
    localparam int LOW_ON_BIT = 7;
    localparam int HIGH_OFF_BIT = 6;
    localparam int HIGH_ON_BIT = 5;
    localparam int NO_WAIT_HI = 4;
    localparam int NO_WAIT_LO = 1;
    localparam int SEQ_DEMAG_MASK_BIT = 0;

    // Field positions in word 1.
    localparam int SEL_C_LO = 24;
    localparam int ANALOG_B_DIRECT_BIT = 22;
    localparam int ANALOG_B_BUF_BIT = 21;
    localparam int SEL_B_LO = 16;
    localparam int ANALOG_A_DIRECT_BIT = 15;
    localparam int ANALOG_A_BUF_BIT = 14;
    localparam int PROBE_ENABLE_BIT = 13;
    localparam int SEL_A_LO = 8;
    localparam int HOLD_SKIP_BIT = 4;
    localparam int SEL_WIDTH = 5;

    // Field positions in word 2.
    localparam int QUALIFIER_HI = 14;

    // Probe selector codes with a fixed meaning.
    localparam logic [4:0] SEL_A_HIGH_SWITCH = 5'h1E;
    localparam logic [4:0] SEL_A_LOW_SWITCH = 5'h1F;
    localparam logic [4:0] SEL_B_RESET_N = 5'h05;
    localparam logic [4:0] SEL_B_REG_CLK = 5'h06;
    localparam logic [4:0] SEL_B_TIE_HI0 = 5'h1B;
    localparam logic [4:0] SEL_B_TIE_LO0 = 5'h1C;
    localparam logic [4:0] SEL_B_TIE_HI1 = 5'h1D;
    localparam logic [4:0] SEL_B_TIE_LO1 = 5'h1E;
    localparam logic [4:0] SEL_B_TIE_HI2 = 5'h1F;
    localparam logic [4:0] SEL_C_REG_ENABLE = 5'h06;
    localparam logic [4:0] SEL_C_REG_BYPASS = 5'h07;
    localparam logic [4:0] SEL_C_REG_START = 5'h08;
    localparam logic [4:0] SEL_C_TIE_LO = 5'h1E;

    // Internal controller state offered to the digital probe selectors.
    typedef struct packed {
        logic [31:0] probe_a_src;
        logic [31:0] probe_b_src;
        logic [31:0] probe_c_src;
        logic regulator_enable;
        logic regulator_bypass;
        logic regulator_start;
    } regulator_status_s;

endpackage : trim_regs_pkg

// ==== core/buck_trim_debug_regs.sv ====
// Key-protected trim and debug register bank of the step-down regulator.
// Assumes registers are reached over a plain strobe port on clk, and that
// all regulator-side inputs are already synchronous to clk.
//
// Overview of operation
// - Fixed-frequency event mask suppresses, inject adds.
// - Pulse-skip event mask suppresses, inject adds.
// - Hold bits pin regulator in either mode.
// - Gate bit stops main fast clock.
// - Ignore bit blocks bypass stop conditions.
// - Clock override drives both switch enables.
// - Eight bits choose ignored sequencer timeouts.
// - Force bits raise magnetize and demagnetize requests.
// - Four bits choose sequencer pause step.
// - Low switch forced off or on.
// - High switch forced off; on only debug.
// - Mask bits hide requests from sequencer.
// - Four bits skip waiting on switch flags.
// - Enable bit and three selectors drive probes.
// - First probe routes states and switch enables.
// - Second probe routes reset, clock, ties.
// - Third probe routes enable, bypass, start, low.
// - Four bits enable analog probe paths.
// - Third word holds start/stop event qualifiers.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

module buck_trim_debug_regs
    import trim_regs_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Register port.
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    output logic [31:0] rdata,
    // Raw controller events and conditions.
    input wire logic fixed_freq_event_in,
    input wire logic pulse_skip_event_in,
    input wire logic counter_bypass,
    input wire logic comparator_bypass,
    input wire logic debug_mode,
    input wire logic regulator_clk,
    // Sequencer switch drives and requests.
    input wire logic seq_high_switch,
    input wire logic seq_low_switch,
    input wire logic magnetize_request_in,
    input wire logic demagnetize_request_in,
    // Internal state offered to the probes.
    input wire regulator_status_s status,
    // Mode and event outputs to the main state machine.
    output logic hold_fixed_freq_mode,
    output logic hold_pulse_skip_mode,
    output logic to_fixed_freq_event,
    output logic to_pulse_skip_event,
    output logic main_fast_clock_gate,
    output logic bypass_stop_request,
    // Switch drives and sequencer controls.
    output logic high_switch_enable,
    output logic low_switch_enable,
    output logic [7:0] sequencer_timeout_ignore,
    output logic [3:0] sequencer_pause_step,
    output logic [3:0] flag_wait_bypass,
    output logic magnetize_request,
    output logic demagnetize_request,
    output logic sequencer_magnetize_request,
    output logic sequencer_demagnetize_request,
    // Test buses and event qualifiers.
    output logic [2:0] digital_probe,
    output logic [3:0] analog_probe_enable,
    output logic [14:0] event_qualifiers,
    output logic trim_unlocked
);

    // Stored unlock key as last written by software.
    logic [31:0] trim_unlock_key;
    // The four trim words.
    logic [31:0] trim_word [NUM_WORDS];
    // Word reset values, indexed like the words.
    logic [31:0] word_reset [NUM_WORDS];
    // High when the key matches the unlock value.
    logic unlocked;
    // Address falls on one of the trim words.
    logic word_hit;
    // Index of the addressed word.
    logic [1:0] word_index;
    // Next value of the read data.
    logic [31:0] next_rdata;
    // Source vectors of the three probe selectors.
    logic [31:0] probe_src [3];
    // Selector codes of the three probes.
    logic [4:0] probe_sel [3];
    // Merged requests before the sequencer masks.
    logic mag_merged;
    logic demag_merged;
    // Next values of the switch enables.
    logic next_high_switch;
    logic next_low_switch;

    assign word_reset[0] = WORD0_RESET;
    assign word_reset[1] = WORD1_RESET;
    assign word_reset[2] = WORD2_RESET;
    assign word_reset[3] = WORD3_RESET;

    // Decode: word block sits on aligned words from the first word upward.
    assign word_hit = (addr[31:4] == ADDR_WORD0[31:4]) && (addr[1:0] == 2'b00);
    assign word_index = addr[3:2];
    assign unlocked = (trim_unlock_key == UNLOCK_VALUE);

    // The key register always accepts writes so software can lock again.
    always_ff @(posedge clk) begin
        if (rst) begin
            trim_unlock_key <= 32'h00000000;
        end else if (wr_strobe && addr == ADDR_UNLOCK) begin
            trim_unlock_key <= wdata;
        end
    end

    // One storage process per trim word; writes only land while unlocked.
    genvar gw;
    generate
        for (gw = 0; gw < NUM_WORDS; gw++) begin : g_word
            always_ff @(posedge clk) begin
                if (rst) begin
                    trim_word[gw] <= word_reset[gw];
                end else if (wr_strobe && word_hit && unlocked &&
                             word_index == 2'(gw)) begin
                    trim_word[gw] <= wdata;
                end
            end
        end
    endgenerate

    // Read data: words read zero while locked, key reads its lock state.
    always_comb begin
        next_rdata = 32'h00000000;
        if (rd_strobe) begin
            if (word_hit && unlocked) begin
                next_rdata = trim_word[word_index];
            end else if (addr == ADDR_UNLOCK) begin
                next_rdata = {31'h00000000, unlocked};
            end
        end
    end

    // Read data stand for exactly the cycle after the strobe.
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 32'h00000000;
        end else begin
            rdata <= next_rdata;
        end
    end

    // Mode holds, events and the bypass stop request.
    always_ff @(posedge clk) begin
        if (rst) begin
            hold_fixed_freq_mode <= 1'b0;
            hold_pulse_skip_mode <= 1'b0;
            to_fixed_freq_event <= 1'b0;
            to_pulse_skip_event <= 1'b0;
            main_fast_clock_gate <= 1'b0;
            bypass_stop_request <= 1'b0;
        end else begin
            hold_fixed_freq_mode <= trim_word[0][HOLD_FIXED_BIT];
            hold_pulse_skip_mode <= trim_word[1][HOLD_SKIP_BIT];
            // Inject wins over mask so a forced event always appears.
            to_fixed_freq_event <= (fixed_freq_event_in &
                                    ~trim_word[0][FIXED_MASK_BIT]) |
                                   trim_word[0][FIXED_INJECT_BIT];
            to_pulse_skip_event <= (pulse_skip_event_in &
                                    ~trim_word[0][SKIP_MASK_BIT]) |
                                   trim_word[0][SKIP_INJECT_BIT];
            main_fast_clock_gate <= trim_word[0][FAST_GATE_BIT];
            bypass_stop_request <= (counter_bypass | comparator_bypass) &
                                   ~trim_word[0][IGNORE_BYPASS_BIT];
        end
    end

    // Switch enables: clock override, then force on, then force off wins.
    always_comb begin
        next_high_switch = seq_high_switch;
        next_low_switch = seq_low_switch;
        if (trim_word[0][CLOCK_DRIVES_BIT]) begin
            next_high_switch = regulator_clk;
            next_low_switch = regulator_clk;
        end
        if (trim_word[0][LOW_ON_BIT]) begin
            next_low_switch = 1'b1;
        end
        if (trim_word[0][HIGH_ON_BIT] && debug_mode) begin
            next_high_switch = 1'b1;
        end
        // Forcing off is the safe direction, so it has the last word.
        if (trim_word[0][LOW_OFF_BIT]) begin
            next_low_switch = 1'b0;
        end
        if (trim_word[0][HIGH_OFF_BIT]) begin
            next_high_switch = 1'b0;
        end
    end

    // Registered switch enables.
    always_ff @(posedge clk) begin
        if (rst) begin
            high_switch_enable <= 1'b0;
            low_switch_enable <= 1'b0;
        end else begin
            high_switch_enable <= next_high_switch;
            low_switch_enable <= next_low_switch;
        end
    end

    // Requests are forced high first, then masked toward the sequencer.
    assign mag_merged = magnetize_request_in | trim_word[0][FORCE_MAG_BIT];
    assign demag_merged = demagnetize_request_in |
                          trim_word[0][FORCE_DEMAG_BIT];

    // Sequencer controls and requests.
    always_ff @(posedge clk) begin
        if (rst) begin
            sequencer_timeout_ignore <= 8'h00;
            sequencer_pause_step <= 4'h0;
            flag_wait_bypass <= 4'h0;
            magnetize_request <= 1'b0;
            demagnetize_request <= 1'b0;
            sequencer_magnetize_request <= 1'b0;
            sequencer_demagnetize_request <= 1'b0;
        end else begin
            sequencer_timeout_ignore <=
                trim_word[0][TIMEOUT_IGN_HI:TIMEOUT_IGN_LO];
            sequencer_pause_step <= trim_word[0][PAUSE_HI:PAUSE_LO];
            flag_wait_bypass <= trim_word[0][NO_WAIT_HI:NO_WAIT_LO];
            magnetize_request <= mag_merged;
            demagnetize_request <= demag_merged;
            sequencer_magnetize_request <= mag_merged &
                ~trim_word[0][SEQ_MAG_MASK_BIT];
            sequencer_demagnetize_request <= demag_merged &
                ~trim_word[0][SEQ_DEMAG_MASK_BIT];
        end
    end

    // Probe sources: the status vectors with the fixed codes patched in.
    always_comb begin
        probe_src[0] = status.probe_a_src;
        probe_src[0][SEL_A_HIGH_SWITCH] = high_switch_enable;
        probe_src[0][SEL_A_LOW_SWITCH] = low_switch_enable;
        probe_src[1] = status.probe_b_src;
        probe_src[1][SEL_B_RESET_N] = ~rst;
        probe_src[1][SEL_B_REG_CLK] = regulator_clk;
        probe_src[1][SEL_B_TIE_HI0] = 1'b1;
        probe_src[1][SEL_B_TIE_LO0] = 1'b0;
        probe_src[1][SEL_B_TIE_HI1] = 1'b1;
        probe_src[1][SEL_B_TIE_LO1] = 1'b0;
        probe_src[1][SEL_B_TIE_HI2] = 1'b1;
        probe_src[2] = status.probe_c_src;
        probe_src[2][SEL_C_REG_ENABLE] = status.regulator_enable;
        probe_src[2][SEL_C_REG_BYPASS] = status.regulator_bypass;
        probe_src[2][SEL_C_REG_START] = status.regulator_start;
        probe_src[2][SEL_C_TIE_LO] = 1'b0;
    end

    assign probe_sel[0] = trim_word[1][SEL_A_LO +: SEL_WIDTH];
    assign probe_sel[1] = trim_word[1][SEL_B_LO +: SEL_WIDTH];
    assign probe_sel[2] = trim_word[1][SEL_C_LO +: SEL_WIDTH];

    // One selector per probe line; all lines read low while disabled.
    genvar gp;
    generate
        for (gp = 0; gp < 3; gp++) begin : g_probe
            always_ff @(posedge clk) begin
                if (rst) begin
                    digital_probe[gp] <= 1'b0;
                end else begin
                    digital_probe[gp] <= trim_word[1][PROBE_ENABLE_BIT] &
                        probe_src[gp][probe_sel[gp]];
                end
            end
        end
    endgenerate

    // Analog path enables, event qualifiers and the lock status.
    always_ff @(posedge clk) begin
        if (rst) begin
            analog_probe_enable <= 4'h0;
            event_qualifiers <= 15'h0000;
            trim_unlocked <= 1'b0;
        end else begin
            analog_probe_enable <= {trim_word[1][ANALOG_B_DIRECT_BIT],
                                    trim_word[1][ANALOG_B_BUF_BIT],
                                    trim_word[1][ANALOG_A_DIRECT_BIT],
                                    trim_word[1][ANALOG_A_BUF_BIT]};
            event_qualifiers <= trim_word[2][QUALIFIER_HI:0];
            trim_unlocked <= unlocked;
        end
    end

    // Key written, then a word written, then the word holds the data.
    sequence unlock_then_write_s;
        wr_strobe && addr == ADDR_UNLOCK && wdata == UNLOCK_VALUE
        ##1 wr_strobe && addr == ADDR_WORD1;
    endsequence

    unlocked_write_a: assert property (@(posedge clk) disable iff (rst)
        unlock_then_write_s |=> trim_word[1] == $past(wdata))
        else $error("unlocked write did not land");

    // A locked write must leave every word untouched, not just one.
    locked_write_a: assert property (@(posedge clk) disable iff (rst)
        wr_strobe && word_hit && !unlocked |=>
        $stable({trim_word[0], trim_word[1], trim_word[2], trim_word[3]}))
        else $error("write landed while locked");

    locked_read_a: assert property (@(posedge clk) disable iff (rst)
        rd_strobe && word_hit && !unlocked |=> rdata == 32'h00000000)
        else $error("locked read returned data");

    fixed_mask_a: assert property (@(posedge clk) disable iff (rst)
        trim_word[0][FIXED_MASK_BIT] && !trim_word[0][FIXED_INJECT_BIT]
        |=> !to_fixed_freq_event)
        else $error("masked fixed-frequency event passed");

    event_inject_a: assert property (@(posedge clk) disable iff (rst)
        trim_word[0][FIXED_INJECT_BIT] && trim_word[0][SKIP_INJECT_BIT]
        |=> to_fixed_freq_event && to_pulse_skip_event)
        else $error("injected event missing");

    bypass_stop_a: assert property (@(posedge clk) disable iff (rst)
        (counter_bypass || comparator_bypass)
        |=> bypass_stop_request == !$past(trim_word[0][IGNORE_BYPASS_BIT]))
        else $error("bypass stop request wrong");

    high_debug_a: assert property (@(posedge clk) disable iff (rst)
        trim_word[0][HIGH_ON_BIT] && !debug_mode && !seq_high_switch &&
        !trim_word[0][CLOCK_DRIVES_BIT] |=> !high_switch_enable)
        else $error("high switch forced outside debug");

    // Each force-off bit is checked on its own, as software sets them apart.
    switch_off_a: assert property (@(posedge clk) disable iff (rst)
        (trim_word[0][LOW_OFF_BIT] |=> !low_switch_enable) and
        (trim_word[0][HIGH_OFF_BIT] |=> !high_switch_enable))
        else $error("forced-off switch enable high");

    seq_mag_a: assert property (@(posedge clk) disable iff (rst)
        trim_word[0][FORCE_MAG_BIT] |=> magnetize_request &&
        sequencer_magnetize_request == !$past(trim_word[0][SEQ_MAG_MASK_BIT]))
        else $error("magnetize request path wrong");

    probe_off_a: assert property (@(posedge clk) disable iff (rst)
        !trim_word[1][PROBE_ENABLE_BIT] [*2] |-> digital_probe == 3'b000)
        else $error("probe driven while disabled");

endmodule : buck_trim_debug_regs

`default_nettype wire

// ==== sim/buck_trim_debug_regs_test.sv ====
// Self-checking testbench for the key-protected regulator trim bank.
// Assumes the design package and module are compiled first; one 125 MHz clk.
`timescale 1ns/1ns
`default_nettype none

module buck_trim_debug_regs_test
    import trim_regs_pkg::*;
;

    // Compares one value against its expectation and counts the outcome.
    `define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
        num_errors++; $display("[FAIL] %s exp=%h got=%h", nm, ex, got); \
        end end

    // Clock, reset and register port.
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] addr = 32'h0;
    logic [31:0] wdata = 32'h0;
    logic wr_strobe = 1'b0;
    logic rd_strobe = 1'b0;
    logic [31:0] rdata;
    // Regulator-side stimulus.
    logic ff_in = 1'b0, ps_in = 1'b0, cnt_byp = 1'b0, cmp_byp = 1'b0;
    logic debug_mode = 1'b0, reg_clk = 1'b0, seq_hi = 1'b0, seq_lo = 1'b0;
    logic mag_in = 1'b0, demag_in = 1'b0;
    regulator_status_s status_in = '0;
    // Design outputs.
    logic hold_ff, hold_ps, ev_ff, ev_ps, fast_gate, byp_stop, hi_en, lo_en;
    logic [7:0] tmo_ign;
    logic [3:0] pause, no_wait, an_en;
    logic mag_rq, demag_rq, seq_mag, seq_demag, unlocked;
    logic [2:0] dprobe;
    logic [14:0] quals;
    // Scoreboard counters.
    int num_errors = 0;
    int n_checks = 0;
    logic [31:0] rd_val;

    // Free-running clock at 8 ns period.
    always #4 clk = ~clk;

    buck_trim_debug_regs i_buck_trim_debug_regs (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
        .fixed_freq_event_in(ff_in), .pulse_skip_event_in(ps_in),
        .counter_bypass(cnt_byp), .comparator_bypass(cmp_byp),
        .debug_mode(debug_mode), .regulator_clk(reg_clk),
        .seq_high_switch(seq_hi), .seq_low_switch(seq_lo),
        .magnetize_request_in(mag_in), .demagnetize_request_in(demag_in),
        .status(status_in), .hold_fixed_freq_mode(hold_ff),
        .hold_pulse_skip_mode(hold_ps), .to_fixed_freq_event(ev_ff),
        .to_pulse_skip_event(ev_ps), .main_fast_clock_gate(fast_gate),
        .bypass_stop_request(byp_stop), .high_switch_enable(hi_en),
        .low_switch_enable(lo_en), .sequencer_timeout_ignore(tmo_ign),
        .sequencer_pause_step(pause), .flag_wait_bypass(no_wait),
        .magnetize_request(mag_rq), .demagnetize_request(demag_rq),
        .sequencer_magnetize_request(seq_mag),
        .sequencer_demagnetize_request(seq_demag),
        .digital_probe(dprobe), .analog_probe_enable(an_en),
        .event_qualifiers(quals), .trim_unlocked(unlocked)
    );

    // One-cycle write strobe; released at the edge that takes it.
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_strobe <= 1'b1;
        @(posedge clk);
        wr_strobe <= 1'b0;
    endtask : wr

    // One-cycle read; data is sampled in the single cycle it stands.
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge clk);
        rd_strobe <= 1'b0;
        #1 d = rdata;
    endtask : rd

    // Lets registered outputs catch up with a register or input change.
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    // Reset values seen at the outputs and through a locked bank.
    task automatic t_reset();
        cnt_byp <= 1'b1;
        settle();
        `CHK("hold_ff", 1'b1, hold_ff)
        `CHK("hold_ps", 1'b0, hold_ps)
        `CHK("byp_stop", 1'b0, byp_stop)
        `CHK("no_wait", 4'h5, no_wait)
        `CHK("quals", 15'h0808, quals)
        `CHK("tmo_pause", 12'h000, {tmo_ign, pause})
        rd(ADDR_WORD0, rd_val);
        `CHK("locked rd", 32'h0, rd_val)
        $display("test reset done");
    endtask : t_reset

    // Unlock, then read back every word's reset image and a hole.
    task automatic t_unlock();
        wr(ADDR_UNLOCK, UNLOCK_VALUE);
        rd(ADDR_UNLOCK, rd_val);
        `CHK("key rd", 32'h1, rd_val)
        rd(ADDR_WORD0, rd_val);
        `CHK("w0 rst", 32'h8200000A, rd_val)
        rd(ADDR_WORD1, rd_val);
        `CHK("w1 rst", WORD1_RESET, rd_val)
        rd(ADDR_WORD2, rd_val);
        `CHK("w2 rst", 32'h00000808, rd_val)
        rd(ADDR_WORD3, rd_val);
        `CHK("w3 rst", WORD3_RESET, rd_val)
        rd(32'h50018030, rd_val);
        `CHK("hole rd", 32'h0, rd_val)
        $display("test unlock done");
    endtask : t_unlock

    // Event masking and injection for both mode-change events.
    task automatic t_events();
        ff_in <= 1'b1;
        ps_in <= 1'b1;
        wr(ADDR_WORD0, WORD0_RESET);
        settle();
        `CHK("ev pass", 2'b11, {ev_ff, ev_ps})
        wr(ADDR_WORD0, WORD0_RESET | 32'h50000000);
        settle();
        `CHK("ev mask", 2'b00, {ev_ff, ev_ps})
        ff_in <= 1'b0;
        ps_in <= 1'b0;
        wr(ADDR_WORD0, WORD0_RESET | 32'h28000000);
        settle();
        `CHK("ev inject", 2'b11, {ev_ff, ev_ps})
        $display("test events done");
    endtask : t_events

    // One switch-drive case: override bits, sequencer, debug and clock.
    task automatic sw_case(input logic [31:0] w, input logic [3:0] in4,
                           input logic [1:0] ex);
        @(posedge clk);
        {seq_hi, seq_lo, debug_mode, reg_clk} <= in4;
        wr(ADDR_WORD0, w);
        settle();
        `CHK("switches", ex, {hi_en, lo_en})
    endtask : sw_case

    // Sequencer drive alone, then switch overrides, each against an opposing sequencer drive.
    task automatic t_switch();
        sw_case(WORD0_RESET, 4'b1000, 2'b10);
        sw_case(WORD0_RESET | 32'h80, 4'b1000, 2'b11);
        sw_case(WORD0_RESET | 32'h280, 4'b1100, 2'b10);
        sw_case(WORD0_RESET | 32'h40, 4'b1100, 2'b01);
        sw_case(WORD0_RESET | 32'h20, 4'b0000, 2'b00);
        sw_case(WORD0_RESET | 32'h20, 4'b0010, 2'b10);
        sw_case(WORD0_RESET | 32'h01000000, 4'b0001, 2'b11);
        sw_case(WORD0_RESET | 32'h01000000, 4'b1100, 2'b00);
        $display("test switch done");
    endtask : t_switch

    // Sequencer fields, forced and masked requests, gate and bypass.
    task automatic t_fields();
        // Gate, no bypass ignore, timeouts 5A, both forces, pause 9,
        // magnetize mask, flag bypass 4'hA.
        wr(ADDR_WORD0, 32'h845AE514);
        settle();
        `CHK("tmo", 8'h5A, tmo_ign)
        `CHK("pause", 4'h9, pause)
        `CHK("no_wait", 4'hA, no_wait)
        `CHK("gate_byp", 2'b11, {fast_gate, byp_stop})
        `CHK("req", 4'b1101, {mag_rq, demag_rq, seq_mag, seq_demag})
        rd(ADDR_WORD0, rd_val);
        `CHK("w0 back", 32'h845AE514, rd_val)
        wr(ADDR_WORD2, 32'h00001234);
        settle();
        `CHK("quals", 15'h1234, quals)
        $display("test fields done");
    endtask : t_fields

    // One probe case: three selectors with the probe output enabled.
    task automatic pr_case(input logic [4:0] a, input logic [4:0] b,
                           input logic [4:0] c, input logic [2:0] ex);
        wr(ADDR_WORD1, {3'b010, c, 3'b010, b, 3'b101, a, 8'h90});
        settle();
        `CHK("probe", ex, dprobe)
    endtask : pr_case

    // Probe routing of fixed codes, status bits and the enable.
    task automatic t_probe();
        wr(ADDR_WORD0, WORD0_RESET);
        @(posedge clk);
        {seq_hi, seq_lo, debug_mode, reg_clk} <= 4'b1000;
        status_in.probe_a_src <= 32'h00000001;
        status_in.regulator_enable <= 1'b1;
        status_in.regulator_start <= 1'b1;
        pr_case(5'h00, 5'h05, 5'h06, 3'b111);
        pr_case(5'h1F, 5'h1C, 5'h07, 3'b000);
        pr_case(5'h1E, 5'h1B, 5'h08, 3'b111);
        pr_case(5'h03, 5'h06, 5'h1E, 3'b000);
        `CHK("analog", 4'hA, an_en)
        `CHK("hold_ps", 1'b1, hold_ps)
        // Every selector points at a high source, so only the enable hides it.
        wr(ADDR_WORD1, 32'h061B0000);
        settle();
        `CHK("probe off", 3'b000, dprobe)
        $display("test probe done");
    endtask : t_probe

    // A wrong key relocks; locked writes are dropped and reads give zero.
    task automatic t_relock();
        wr(ADDR_WORD3, 32'hA5A5A5A5);
        wr(ADDR_UNLOCK, 32'h1D155AFF);
        settle();
        `CHK("unlocked", 1'b0, unlocked)
        wr(ADDR_WORD3, 32'h12345678);
        rd(ADDR_WORD3, rd_val);
        `CHK("locked w3", 32'h0, rd_val)
        wr(ADDR_UNLOCK, UNLOCK_VALUE);
        rd(ADDR_WORD3, rd_val);
        `CHK("w3 kept", 32'hA5A5A5A5, rd_val)
        $display("test relock done");
    endtask : t_relock

    // Key write, word write and read with no gap between the strobes.
    task automatic t_b2b();
        @(posedge clk);
        addr <= ADDR_UNLOCK;
        wdata <= UNLOCK_VALUE;
        wr_strobe <= 1'b1;
        @(posedge clk);
        addr <= ADDR_WORD1;
        wdata <= 32'h5A00A5C3;
        @(posedge clk);
        wr_strobe <= 1'b0;
        rd_strobe <= 1'b1;
        @(posedge clk);
        rd_strobe <= 1'b0;
        #1 rd_val = rdata;
        `CHK("b2b w1", 32'h5A00A5C3, rd_val)
        $display("test b2b done");
    endtask : t_b2b

    // Prints the counts and the verdict, then stops the run.
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    // Main sequence: reset for three cycles, then every scenario in turn.
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_unlock();
        t_events();
        t_switch();
        t_fields();
        t_probe();
        t_relock();
        t_b2b();
        end_sim();
    end

    // Watchdog: the scenarios need well under a thousand cycles.
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        end_sim();
    end

endmodule : buck_trim_debug_regs_test

`default_nettype wire
